// File: src/rioc_pkg.sv
// rioc_pkg: constants, register map and types for the residual
// instantaneous overcurrent block.
// assumes one 40 MHz clock and a synchronous active-high reset.
package rioc_pkg;

  // sampling, measurement and register port widths
  localparam int SAMPLE_W = 16;
  localparam int MAG_W = 16;
  localparam int PCT_W = 12;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // peak window: samples per network period before the held peak decays
  localparam logic [7:0] PEAK_WINDOW = 8'h14;

  // start threshold in percent of nominal current
  localparam logic [PCT_W-1:0] START_PCT_RESET = 12'h0c8;
  localparam logic [PCT_W-1:0] START_PCT_MIN = 12'h014;
  localparam logic [PCT_W-1:0] START_PCT_MAX = 12'hbb8;
  // magnitude code that equals 100 percent of nominal current
  localparam logic [MAG_W-1:0] NOMINAL_CODE = 16'h0100;
  localparam int PCT_SCALE = 100;

  // register offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_START = 4'h1;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_EN = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 4'h5;
  localparam logic [ADDR_W-1:0] REG_MEAS = 4'h6;

  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int STAT_TRIP_BIT = 0;
  localparam int STAT_GEN_BIT = 1;
  localparam int IRQ_ON_BIT = 0;
  localparam int IRQ_OFF_BIT = 1;
  localparam int IRQ_W = 2;

  typedef enum logic [1:0] {
    RIOC_MODE_OFF = 2'h0,
    RIOC_MODE_PEAK = 2'h1,
    RIOC_MODE_FUND = 2'h2
  } rioc_mode_e;

  // one new sample from the front end
  typedef struct packed {
    logic valid;
    logic signed [SAMPLE_W-1:0] residual;
    logic [MAG_W-1:0] fund_rms;
  } rioc_sample_s;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } rioc_bus_s;

endpackage : rioc_pkg

// File: src/rioc_peak_select.sv
// rioc_peak_select: peak magnitude of the residual current samples.
// assumes a sample valid strobe at the sampling rate.
`timescale 1ns/1ps
`default_nettype none
module rioc_peak_select (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // sample stream
  input wire logic sample_valid,
  input wire logic signed [rioc_pkg::SAMPLE_W-1:0] sample,
  // peak out
  output logic [rioc_pkg::MAG_W-1:0] residual_peak_value,
  output logic peak_valid
);
  import rioc_pkg::*;

  logic [MAG_W-1:0] abs_val;
  logic [MAG_W-1:0] hold;
  logic [7:0] age;
  logic [MAG_W-1:0] next_hold;
  logic [7:0] next_age;
  logic [MAG_W-1:0] next_peak;
  logic next_valid;

  // magnitude, largest negative saturated
  always_comb begin
    if (sample[SAMPLE_W-1]) begin
      abs_val = (sample == {1'b1, {(SAMPLE_W-1){1'b0}}}) ? {MAG_W{1'b1}} :
                MAG_W'(-sample);
    end else begin
      abs_val = MAG_W'(sample);
    end
  end

  always_comb begin
    next_hold = hold;
    next_age = age;
    next_peak = residual_peak_value;
    next_valid = 1'b0;
    if (sample_valid) begin
      if (abs_val >= hold || age >= PEAK_WINDOW) begin
        next_hold = abs_val;
        next_age = 8'h00;
      end else begin
        next_age = age + 8'h01;
      end
      next_peak = (abs_val >= hold || age >= PEAK_WINDOW) ? abs_val : hold;
      next_valid = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hold <= '0;
      age <= '0;
      residual_peak_value <= '0;
      peak_valid <= 1'b0;
    end else begin
      hold <= next_hold;
      age <= next_age;
      residual_peak_value <= next_peak;
      peak_valid <= next_valid;
    end
  end

endmodule : rioc_peak_select
`default_nettype wire

// File: src/rioc_top.sv
// rioc_top: residual instantaneous overcurrent decision block.
// assumes samples and user inputs synchronous to sys_clk, register port
// with read data one cycle after the read strobe.
//
// Overview of operation
// - mode selector off, peak or fundamental; resets off; off never trips
// - start threshold in percent, step 1, up to 3000, reset 200
// - double input compares against twice the start threshold
// - block input holds general trip low
// - internal trip without added delay when quantity exceeds threshold
// - peak mode uses peak value, fundamental mode uses RMS value
// - peak stage derives peak magnitude from the samples
// - general trip is internal trip and not block
// - peak mode sub-cycle response; fundamental may exceed a period
// - operate time fixed, independent of current magnitude
// - measured quantity is sampled residual current, three times zero sequence
// - every general trip change is reported as an on or off event
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rioc_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // measurement front end
  input wire rioc_pkg::rioc_sample_s sample_in,
  // user logic inputs
  input wire logic threshold_double_in,
  input wire logic function_block_in,
  // register port
  input wire rioc_pkg::rioc_bus_s bus_in,
  output logic [rioc_pkg::DATA_W-1:0] rdata,
  // outputs
  output logic internal_trip,
  output logic general_trip_out,
  output logic irq
);
  import rioc_pkg::*;

  rioc_mode_e mode;
  logic [PCT_W-1:0] start_pct;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [MAG_W-1:0] residual_peak_value;
  logic peak_valid;
  logic [MAG_W-1:0] residual_fund_rms;
  logic fund_valid;
  logic [MAG_W-1:0] meas;

  rioc_mode_e next_mode;
  logic [PCT_W-1:0] next_start_pct;
  logic [IRQ_W-1:0] next_irq_stat;
  logic [IRQ_W-1:0] next_irq_en;
  logic [DATA_W-1:0] next_rdata;
  logic next_internal_trip;
  logic next_general_trip;
  logic next_irq;
  logic [MAG_W-1:0] next_meas;

  logic [31:0] thr_scaled;
  logic [31:0] meas_scaled;
  logic [PCT_W:0] eff_pct;
  logic sel_valid;
  logic [MAG_W-1:0] sel_value;
  logic [IRQ_W-1:0] events;

  // peak path answers one cycle after each sample, well inside a period
  rioc_peak_select u_peak (
    .sys_clk(sys_clk),
    .rst(rst),
    .sample_valid(sample_in.valid),
    .sample(sample_in.residual),
    .residual_peak_value(residual_peak_value),
    .peak_valid(peak_valid)
  );

  // fundamental RMS comes from upstream, aligned with the peak path
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      residual_fund_rms <= '0;
      fund_valid <= 1'b0;
    end else begin
      residual_fund_rms <= sample_in.valid ? sample_in.fund_rms : residual_fund_rms;
      fund_valid <= sample_in.valid;
    end
  end

  always_comb begin
    sel_valid = 1'b0;
    sel_value = '0;
    unique case (mode)
      RIOC_MODE_PEAK: begin
        sel_valid = peak_valid;
        sel_value = residual_peak_value;
      end
      RIOC_MODE_FUND: begin
        sel_valid = fund_valid;
        sel_value = residual_fund_rms;
      end
      default: begin
        sel_valid = 1'b0;
        sel_value = '0;
      end
    endcase
  end

  always_comb begin
    eff_pct = threshold_double_in ? {start_pct, 1'b0} : {1'b0, start_pct};
    // compare value*100 against pct*nominal, avoiding a divider
    thr_scaled = 32'(eff_pct) * 32'(NOMINAL_CODE);
    meas_scaled = 32'(sel_value) * 32'(PCT_SCALE);
  end

  always_comb begin
    next_internal_trip = internal_trip;
    next_meas = meas;
    if (mode == RIOC_MODE_OFF) begin
      next_internal_trip = 1'b0;
    end else if (sel_valid) begin
      // same path for every magnitude above threshold
      next_internal_trip = meas_scaled > thr_scaled;
      next_meas = sel_value;
    end
  end

  always_comb begin
    next_general_trip = next_internal_trip && !function_block_in;
  end

  // on and off events of the general trip
  always_comb begin
    events = '0;
    events[IRQ_ON_BIT] = next_general_trip && !general_trip_out;
    events[IRQ_OFF_BIT] = !next_general_trip && general_trip_out;
  end

  // register writes and sticky status; set wins over clear
  always_comb begin
    next_mode = mode;
    next_start_pct = start_pct;
    next_irq_en = irq_en;
    next_irq_stat = irq_stat;
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        REG_CTRL: begin
          if (bus_in.wdata[CTRL_MODE_LSB +: 2] == 2'(RIOC_MODE_PEAK)) begin
            next_mode = RIOC_MODE_PEAK;
          end else if (bus_in.wdata[CTRL_MODE_LSB +: 2] == 2'(RIOC_MODE_FUND)) begin
            next_mode = RIOC_MODE_FUND;
          end else begin
            next_mode = RIOC_MODE_OFF;
          end
        end
        REG_START: begin
          if (bus_in.wdata[PCT_W-1:0] < START_PCT_MIN) begin
            next_start_pct = START_PCT_MIN;
          end else if (bus_in.wdata[PCT_W-1:0] > START_PCT_MAX ||
                       bus_in.wdata[DATA_W-1:PCT_W] != '0) begin
            next_start_pct = START_PCT_MAX;
          end else begin
            next_start_pct = bus_in.wdata[PCT_W-1:0];
          end
        end
        REG_IRQ_EN: next_irq_en = bus_in.wdata[IRQ_W-1:0];
        REG_IRQ_CLR: next_irq_stat = irq_stat & ~bus_in.wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    next_irq_stat = next_irq_stat | events;
    next_irq = |(next_irq_stat & next_irq_en);
  end

  // register reads
  always_comb begin
    next_rdata = '0;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        REG_CTRL: next_rdata = DATA_W'(mode);
        REG_START: next_rdata = DATA_W'(start_pct);
        REG_STATUS: begin
          next_rdata[STAT_TRIP_BIT] = internal_trip;
          next_rdata[STAT_GEN_BIT] = general_trip_out;
        end
        REG_IRQ_STAT: next_rdata = DATA_W'(irq_stat);
        REG_IRQ_EN: next_rdata = DATA_W'(irq_en);
        REG_MEAS: next_rdata = DATA_W'(meas);
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode <= RIOC_MODE_OFF;
      start_pct <= START_PCT_RESET;
      irq_stat <= '0;
      irq_en <= '0;
      rdata <= '0;
      internal_trip <= 1'b0;
      general_trip_out <= 1'b0;
      irq <= 1'b0;
      meas <= '0;
    end else begin
      mode <= next_mode;
      start_pct <= next_start_pct;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
      rdata <= next_rdata;
      internal_trip <= next_internal_trip;
      general_trip_out <= next_general_trip;
      irq <= next_irq;
      meas <= next_meas;
    end
  end

  // residual samples feed only the peak path; the fundamental path takes fund_rms from upstream

  // assertions
  // off never trips
  AST_OFF_NO_TRIP: assert property (@(posedge sys_clk) disable iff (rst)
    $past(mode) == RIOC_MODE_OFF |-> !internal_trip)
    else $error("trip while mode off");
  AST_BLOCK_GATES: assert property (@(posedge sys_clk) disable iff (rst)
    $past(function_block_in) |-> !general_trip_out)
    else $error("general trip while blocked");
  AST_GEN_EQ: assert property (@(posedge sys_clk) disable iff (rst)
    general_trip_out == (internal_trip && !$past(function_block_in)))
    else $error("general trip mismatch");
  AST_PICKUP: assert property (@(posedge sys_clk) disable iff (rst)
    (mode != RIOC_MODE_OFF && sel_valid && meas_scaled > thr_scaled) ##1 1'b1
    |-> internal_trip)
    else $error("missed pickup");
  AST_DROPOUT: assert property (@(posedge sys_clk) disable iff (rst)
    (sel_valid && meas_scaled <= thr_scaled) |=> !internal_trip)
    else $error("trip held below threshold");
  AST_DOUBLE: assert property (@(posedge sys_clk) disable iff (rst)
    threshold_double_in |-> eff_pct == {start_pct, 1'b0})
    else $error("threshold not doubled");
  AST_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
    start_pct >= START_PCT_MIN && start_pct <= START_PCT_MAX)
    else $error("threshold out of range");
  AST_EVENT_ON: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(general_trip_out) |-> irq_stat[IRQ_ON_BIT])
    else $error("on event lost");
  AST_SELECT: assert property (@(posedge sys_clk) disable iff (rst)
    (mode == RIOC_MODE_PEAK && peak_valid) |=> meas == $past(residual_peak_value))
    else $error("wrong quantity selected");

  COV_PEAK_TRIP: cover property (@(posedge sys_clk) disable iff (rst)
    mode == RIOC_MODE_PEAK && $rose(general_trip_out));
  COV_FUND_TRIP: cover property (@(posedge sys_clk) disable iff (rst)
    mode == RIOC_MODE_FUND && $rose(general_trip_out));
  COV_BLOCKED: cover property (@(posedge sys_clk) disable iff (rst)
    internal_trip && function_block_in);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq));

endmodule : rioc_top
`default_nettype wire

// File: bench/rioc_front_model.sv
// rioc_front_model: sampling front end, residual samples plus rms.
// assumes the bench sets amplitude and rms; one sample every 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module rioc_front_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // wanted wave
  input wire logic [15:0] amp,
  input wire logic [rioc_pkg::MAG_W-1:0] rms,
  // sample stream
  output var rioc_pkg::rioc_sample_s smp
);
  import rioc_pkg::*;
  logic [1:0] phase;
  logic pos;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      phase <= 2'h0;
      pos <= 1'b0;
      smp <= '0;
    end else begin
      phase <= phase + 2'h1;
      smp.valid <= (phase == 2'h3);
      if (phase == 2'h3) begin
        pos <= ~pos;
        smp.residual <= pos ? amp : 16'h0 - amp;
        smp.fund_rms <= rms;
      end else begin
        // between samples the lines carry junk
        smp.residual <= ~smp.residual;
        smp.fund_rms <= ~smp.fund_rms;
      end
    end
  end
endmodule : rioc_front_model
`default_nettype wire

// File: bench/rioc_top_test.sv
// rioc_top_test: self-checking bench for the overcurrent block.
// assumes rioc_top and the front end model; register port per hand-over.
`timescale 1ns/1ps
`default_nettype none
module rioc_top_test;
  import rioc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  rioc_bus_s bus = '0;
  rioc_sample_s smp;
  logic dbl = 1'b0;
  logic blk = 1'b0;
  logic [15:0] amp = 16'h0;
  logic [MAG_W-1:0] rms = '0;
  logic [DATA_W-1:0] rdata;
  logic itrip;
  logic gtrip;
  logic irq;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;

  always #12.5 sys_clk = ~sys_clk;

  rioc_front_model fe (.sys_clk(sys_clk), .rst(rst), .amp(amp), .rms(rms), .smp(smp));
  rioc_top uut (.sys_clk(sys_clk), .rst(rst), .sample_in(smp), .threshold_double_in(dbl),
    .function_block_in(blk), .bus_in(bus), .rdata(rdata), .internal_trip(itrip),
    .general_trip_out(gtrip), .irq(irq));

  task automatic test_done;
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus <= '0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge sys_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge sys_clk);
    bus <= '0;
    #1 chk(rdata, e);
  endtask : rd

  // covers more than the 20 sample peak window
  task automatic settle;
    repeat (120) @(posedge sys_clk);
  endtask : settle

  function automatic logic exp_trip(input logic [1:0] m, input logic [15:0] pk,
      input logic [15:0] fr, input logic [11:0] pct, input logic d);
    logic [31:0] v;
    v = (m == RIOC_MODE_PEAK) ? pk : fr;
    if (m != RIOC_MODE_PEAK && m != RIOC_MODE_FUND) return 1'b0;
    return v * 100 > pct * 32'h100 * (d ? 2 : 1);
  endfunction : exp_trip

  initial begin
    logic [1:0] m;
    logic [11:0] pct;
    logic [15:0] a;
    logic [15:0] r;
    logic d;
    logic b;
    logic e;
    void'($urandom(17));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    rd(REG_CTRL, 32'h0);
    rd(REG_START, 32'h0c8);
    rd(REG_IRQ_EN, 32'h0);
    rd(4'hf, 32'h0);
    wr(REG_START, 32'h5);
    rd(REG_START, 32'h14);
    wr(REG_START, 32'hbb9);
    rd(REG_START, 32'hbb8);
    wr(REG_START, 32'h0c8);
    amp <= 16'h4000;
    rms <= 16'hffff;
    settle();
    chk(32'(itrip), 32'h0);
    wr(REG_IRQ_EN, 32'h3);
    wr(REG_CTRL, 32'h1);
    settle();
    chk(32'(gtrip), 32'h1);
    rd(REG_IRQ_STAT, 32'h1);
    chk(32'(irq), 32'h1);
    wr(REG_IRQ_CLR, 32'h1);
    rd(REG_IRQ_STAT, 32'h0);
    chk(32'(irq), 32'h0);
    amp <= 16'h0;
    settle();
    rd(REG_IRQ_STAT, 32'h2);
    wr(REG_IRQ_EN, 32'h1);
    rd(REG_IRQ_CLR, 32'h0);
    chk(32'(irq), 32'h0);
    wr(REG_IRQ_CLR, 32'h3);
    // first two trials sit exactly at and one code above the threshold
    for (int i = 0; i < 40; i++) begin
      m = (i < 2) ? 2'h1 : 2'($urandom_range(3, 0));
      pct = (i < 2) ? 12'h0c8 : 12'($urandom_range(3000, 20));
      a = (i < 2) ? 16'h200 + 16'(i) : 16'($urandom_range(16384, 0));
      r = 16'($urandom_range(16384, 0));
      d = (i > 1) && ($urandom_range(1, 0) == 1);
      b = (i > 1) && ($urandom_range(3, 0) == 0);
      wr(REG_CTRL, 32'(m));
      wr(REG_START, 32'(pct));
      amp <= a;
      rms <= r;
      dbl <= d;
      blk <= b;
      settle();
      e = exp_trip(m, a, r, pct, d);
      chk(32'(itrip), 32'(e));
      chk(32'(gtrip), 32'(e & ~b));
      rd(REG_STATUS, {30'h0, e & ~b, e});
      if (m == 2'h1 || m == 2'h2) begin
        rd(REG_MEAS, (m == 2'h1) ? 32'(a) : 32'(r));
      end
    end
    test_done();
  end
endmodule : rioc_top_test
`default_nettype wire
